/* core/scs_clock_switch.sv */
// system clock source select, glitch-free switch sequencer and apb registers
// assumes oscillator pins and ready flags are asynchronous; apb on pclk
`timescale 1ns/10ps
module scs_clock_switch (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator pins
  input  wire logic        hf_osc_in,
  input  wire logic        lf_osc_in,
  input  wire logic        ext_clk_in,
  input  wire logic        hf_osc_running,
  input  wire logic        hf_osc_settled,
  input  wire logic        lf_osc_running,
  input  wire logic [1:0]  cfg_osc_select,
  // clock outputs
  output logic             sys_clk,
  output logic             hf_osc_enable,
  output logic             lf_osc_enable,
  output logic             switch_busy,
  output logic             irq
);

  // -----------------------------------------------------------------
  // pin synchronisers and postscaler
  // -----------------------------------------------------------------
  scs_osc_if osc ();
  logic [scs_pkg::SYNC_W-1:0] raw_pins;

  assign raw_pins = {cfg_osc_select, lf_osc_running, hf_osc_settled,
                     hf_osc_running, ext_clk_in, lf_osc_in, hf_osc_in};

  scs_sync3 #(.N(scs_pkg::SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .raw     (raw_pins),
    .osc     (osc.sync_mp)
  );

  scs_postscaler u_post (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .osc     (osc.post_mp)
  );

  logic       hf_rdy;
  logic       lf_rdy;
  logic       hf_set;
  logic [1:0] cfg_sel;

  assign hf_rdy  = osc.lvl[scs_pkg::IDX_HF_RDY];
  assign lf_rdy  = osc.lvl[scs_pkg::IDX_LF_RDY];
  assign hf_set  = osc.lvl[scs_pkg::IDX_HF_SET];
  assign cfg_sel = osc.lvl[scs_pkg::IDX_CFG_LSB+1:scs_pkg::IDX_CFG_LSB];

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // divide exponent of HF for each internal frequency code
  function automatic logic [3:0] freq_exp(input logic [3:0] code);
    case (code)
      4'hf:    freq_exp = 4'h0; // 16 MHz
      4'he:    freq_exp = 4'h1;
      4'hd:    freq_exp = 4'h2;
      4'hc:    freq_exp = 4'h3;
      4'hb:    freq_exp = 4'h4; // 1 MHz
      4'ha:    freq_exp = 4'h5; // 500 kHz duplicate
      4'h9:    freq_exp = 4'h6;
      4'h8:    freq_exp = 4'h7;
      4'h7:    freq_exp = 4'h5; // 500 kHz
      4'h6:    freq_exp = 4'h6;
      4'h5:    freq_exp = 4'h7;
      4'h4:    freq_exp = 4'h8; // 62.5 kHz
      default: freq_exp = 4'h9; // 31.25 kHz
    endcase
  endfunction : freq_exp

  // level of a source at a given divide exponent
  function automatic logic src_level(input scs_pkg::scs_src_t src, input logic [3:0] e,
                                     input logic [scs_pkg::SYNC_W-1:0] l,
                                     input logic [scs_pkg::POST_W-1:0] d);
    logic [3:0] idx;
    idx = e - 4'h1;
    case (src)
      scs_pkg::SCS_SRC_EXT: src_level = l[scs_pkg::IDX_EXT];
      scs_pkg::SCS_SRC_LF:  src_level = l[scs_pkg::IDX_LF];
      default:              src_level = (e == 4'h0) ? l[scs_pkg::IDX_HF] : d[idx];
    endcase
  endfunction : src_level

  // -----------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------
  logic [3:0]             ctrl_freq;
  logic [1:0]             ctrl_scs;
  logic [scs_pkg::IRQ_W-1:0] irq_status;
  logic [scs_pkg::IRQ_W-1:0] irq_mask;
  logic [scs_pkg::IRQ_W-1:0] irq_snap;
  scs_pkg::scs_state_t    state;
  scs_pkg::scs_src_t      act_src;
  logic [3:0]             act_exp;
  scs_pkg::scs_src_t      tgt_src;
  logic [3:0]             tgt_exp;
  logic [7:0]             wait_cnt;
  logic [1:0]             edge_cnt;
  logic                   cur_prev;
  logic                   new_prev;
  logic                   stat_hf_rdy;
  logic                   stat_lf_rdy;
  logic                   stat_hf_stable;

  logic [3:0]             next_ctrl_freq;
  logic [1:0]             next_ctrl_scs;
  logic [scs_pkg::IRQ_W-1:0] next_irq_status;
  logic [scs_pkg::IRQ_W-1:0] next_irq_mask;
  logic [scs_pkg::IRQ_W-1:0] next_irq_snap;
  logic [31:0]            next_prdata;
  scs_pkg::scs_state_t    next_state;
  scs_pkg::scs_src_t      next_act_src;
  logic [3:0]             next_act_exp;
  scs_pkg::scs_src_t      next_tgt_src;
  logic [3:0]             next_tgt_exp;
  logic [7:0]             next_wait_cnt;
  logic [1:0]             next_edge_cnt;
  logic                   next_sys_clk;
  logic                   next_hf_en;
  logic                   next_lf_en;
  logic                   next_stat_hf_rdy;
  logic                   next_stat_lf_rdy;
  logic                   next_stat_hf_stable;

  // -----------------------------------------------------------------
  // requested source decode
  // -----------------------------------------------------------------
  scs_pkg::scs_src_t want_src;
  logic [3:0]        want_exp;
  logic              int_lf;
  logic              need_switch;
  logic              cur_lvl;
  logic              new_lvl;
  logic              want_rdy;

  // internal block: codes 000x pick LF, everything else is postscaled HF
  always_comb begin
    int_lf   = (ctrl_freq[3:1] == 3'h0);
    want_src = act_src;
    want_exp = act_exp;
    if (ctrl_scs[1]) begin
      want_src = int_lf ? scs_pkg::SCS_SRC_LF : scs_pkg::SCS_SRC_HF;
      want_exp = int_lf ? 4'h0 : freq_exp(ctrl_freq);
    end else if (ctrl_scs == scs_pkg::SCS_CONFIG) begin
      if (cfg_sel == scs_pkg::CFG_INTERNAL_OSC_BLOCK) begin
        want_src = int_lf ? scs_pkg::SCS_SRC_LF : scs_pkg::SCS_SRC_HF;
        want_exp = int_lf ? 4'h0 : freq_exp(ctrl_freq);
      end else begin
        want_src = scs_pkg::SCS_SRC_EXT;
        want_exp = 4'h0;
      end
    end
    // reserved select leaves want equal to active, so nothing moves
    need_switch = (want_src != act_src) || (want_exp != act_exp);
    case (want_src)
      scs_pkg::SCS_SRC_HF: want_rdy = hf_rdy;
      scs_pkg::SCS_SRC_LF: want_rdy = lf_rdy;
      default:             want_rdy = 1'b1;
    endcase
    cur_lvl = src_level(act_src, act_exp, osc.lvl, osc.div_cnt);
    new_lvl = src_level(tgt_src, tgt_exp, osc.lvl, osc.div_cnt);
  end

  // -----------------------------------------------------------------
  // switch sequencer
  // -----------------------------------------------------------------
  logic       tgt_rdy;
  logic [1:0] need_edges;
  logic       startup_done;
  logic       switch_done;

  always_comb begin
    case (tgt_src)
      scs_pkg::SCS_SRC_HF: tgt_rdy = hf_rdy;
      scs_pkg::SCS_SRC_LF: tgt_rdy = lf_rdy;
      default:             tgt_rdy = 1'b1;
    endcase
    case (tgt_src)
      scs_pkg::SCS_SRC_EXT: need_edges = scs_pkg::EXT_SWITCH_EDGES;
      scs_pkg::SCS_SRC_LF:  need_edges = scs_pkg::LF_SWITCH_EDGES;
      default:              need_edges = 2'h0;
    endcase
    // HF needs its settle time, LF and external need new-clock edges
    startup_done = tgt_rdy && (edge_cnt >= need_edges) &&
                   ((tgt_src != scs_pkg::SCS_SRC_HF) || (wait_cnt >= scs_pkg::HF_SWITCH_CYC));
    next_state    = state;
    next_act_src  = act_src;
    next_act_exp  = act_exp;
    next_tgt_src  = tgt_src;
    next_tgt_exp  = tgt_exp;
    next_wait_cnt = wait_cnt;
    next_edge_cnt = edge_cnt;
    next_sys_clk  = cur_lvl;
    switch_done   = 1'b0;
    case (state)
      scs_pkg::SCS_ST_IDLE: begin
        if (need_switch) begin
          next_tgt_src  = want_src;
          next_tgt_exp  = want_exp;
          next_wait_cnt = 8'h00;
          next_edge_cnt = 2'h0;
          // a change within the same running source skips the start-up wait
          if ((want_src != act_src) || !want_rdy) begin
            next_state = scs_pkg::SCS_ST_STARTUP;
          end else begin
            next_state = scs_pkg::SCS_ST_WAIT_FALL;
          end
        end
      end
      scs_pkg::SCS_ST_STARTUP: begin
        if (tgt_rdy && (wait_cnt != 8'hff)) begin
          next_wait_cnt = wait_cnt + 8'h01;
        end
        if (tgt_rdy && new_lvl && !new_prev && (edge_cnt != 2'h3)) begin
          next_edge_cnt = edge_cnt + 2'h1;
        end
        if (startup_done) begin
          next_state = scs_pkg::SCS_ST_WAIT_FALL;
        end
      end
      scs_pkg::SCS_ST_WAIT_FALL: begin
        // old clock keeps its full high phase until it falls itself
        if (cur_prev && !cur_lvl) begin
          next_state = scs_pkg::SCS_ST_HOLD_LOW;
        end
      end
      scs_pkg::SCS_ST_HOLD_LOW: begin
        next_sys_clk = 1'b0;
        // only a fresh rising edge hands over, so the high phase is whole
        if (new_lvl && !new_prev) begin
          next_sys_clk = 1'b1;
          next_act_src = tgt_src;
          next_act_exp = tgt_exp;
          next_state   = scs_pkg::SCS_ST_UPDATE;
        end
      end
      scs_pkg::SCS_ST_UPDATE: begin
        next_sys_clk = new_lvl;
        switch_done  = 1'b1;
        next_state   = scs_pkg::SCS_ST_IDLE;
      end
      default: begin
        next_state = scs_pkg::SCS_ST_IDLE;
      end
    endcase
    next_hf_en = (next_act_src == scs_pkg::SCS_SRC_HF) ||
                 ((next_state != scs_pkg::SCS_ST_IDLE) && (next_tgt_src == scs_pkg::SCS_SRC_HF));
    next_lf_en = (next_act_src == scs_pkg::SCS_SRC_LF) ||
                 ((next_state != scs_pkg::SCS_ST_IDLE) && (next_tgt_src == scs_pkg::SCS_SRC_LF));
  end

  // -----------------------------------------------------------------
  // oscillator status
  // -----------------------------------------------------------------
  // frozen mid-switch so software never sees a half-done handover
  always_comb begin
    next_stat_hf_rdy    = stat_hf_rdy;
    next_stat_lf_rdy    = stat_lf_rdy;
    next_stat_hf_stable = stat_hf_stable;
    if ((state == scs_pkg::SCS_ST_IDLE) || (state == scs_pkg::SCS_ST_UPDATE)) begin
      next_stat_hf_rdy    = hf_rdy;
      next_stat_lf_rdy    = lf_rdy;
      // settled pin means within tolerance of the final frequency
      next_stat_hf_stable = hf_rdy && hf_set && (act_src == scs_pkg::SCS_SRC_HF);
    end
  end

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        mapped;
  logic [31:0] rd_word;
  logic [scs_pkg::IRQ_W-1:0] events;

  assign pready  = clk_en; // a frozen block stalls the bus
  assign access  = psel && penable && clk_en;
  assign setup   = psel && !penable;
  assign pslverr = psel && penable && !mapped;

  // address decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == scs_pkg::ADDR_CONTROL) begin
      rd_word[scs_pkg::FREQ_MSB:scs_pkg::FREQ_LSB] = ctrl_freq;
      rd_word[scs_pkg::SCS_MSB:scs_pkg::SCS_LSB]   = ctrl_scs;
    end else if (paddr == scs_pkg::ADDR_STATUS) begin
      rd_word[scs_pkg::STAT_HF_RDY_BIT]    = stat_hf_rdy;
      rd_word[scs_pkg::STAT_LF_RDY_BIT]    = stat_lf_rdy;
      rd_word[scs_pkg::STAT_HF_STABLE_BIT] = stat_hf_stable;
    end else if (paddr == scs_pkg::ADDR_IRQ_STATUS) begin
      rd_word[scs_pkg::IRQ_W-1:0] = irq_status;
    end else if (paddr == scs_pkg::ADDR_IRQ_MASK) begin
      rd_word[scs_pkg::IRQ_W-1:0] = irq_mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // register writes, read capture and sticky events
  always_comb begin
    next_ctrl_freq = ctrl_freq;
    next_ctrl_scs  = ctrl_scs;
    next_irq_mask  = irq_mask;
    next_irq_snap  = irq_snap;
    next_prdata    = prdata;
    events         = '0;
    if (setup) begin
      next_prdata   = pwrite ? 32'h0000_0000 : rd_word;
      next_irq_snap = (!pwrite && (paddr == scs_pkg::ADDR_IRQ_STATUS)) ? irq_status : '0;
    end
    if (access && pwrite) begin
      if (paddr == scs_pkg::ADDR_CONTROL) begin
        next_ctrl_freq = pwdata[scs_pkg::FREQ_MSB:scs_pkg::FREQ_LSB];
        next_ctrl_scs  = pwdata[scs_pkg::SCS_MSB:scs_pkg::SCS_LSB];
        events[scs_pkg::IRQ_RESVD_SEL_BIT] =
          (pwdata[scs_pkg::SCS_MSB:scs_pkg::SCS_LSB] == scs_pkg::SCS_RESVD);
      end else if (paddr == scs_pkg::ADDR_IRQ_MASK) begin
        next_irq_mask = pwdata[scs_pkg::IRQ_W-1:0];
      end
    end
    events[scs_pkg::IRQ_SWITCH_DONE_BIT] = switch_done;
    events[scs_pkg::IRQ_HF_STABLE_BIT]   = next_stat_hf_stable && !stat_hf_stable;
    // clear only what the read returned; a new event always wins
    next_irq_status = irq_status;
    if (access && !pwrite && (paddr == scs_pkg::ADDR_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~irq_snap;
    end
    next_irq_status = next_irq_status | events;
  end

  assign irq         = |(irq_status & irq_mask);
  assign switch_busy = (state != scs_pkg::SCS_ST_IDLE);

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_freq      <= scs_pkg::FREQ_RESET;
      ctrl_scs       <= scs_pkg::SCS_RESET;
      irq_status     <= scs_pkg::IRQ_RESET;
      irq_mask       <= scs_pkg::IRQ_RESET;
      irq_snap       <= scs_pkg::IRQ_RESET;
      prdata         <= 32'h0000_0000;
      state          <= scs_pkg::SCS_ST_IDLE;
      act_src        <= scs_pkg::SCS_SRC_HF;
      act_exp        <= scs_pkg::RESET_EXP;
      tgt_src        <= scs_pkg::SCS_SRC_HF;
      tgt_exp        <= scs_pkg::RESET_EXP;
      wait_cnt       <= 8'h00;
      edge_cnt       <= 2'h0;
      cur_prev       <= 1'b0;
      new_prev       <= 1'b0;
      sys_clk        <= 1'b0;
      hf_osc_enable  <= 1'b1;
      lf_osc_enable  <= 1'b0;
      stat_hf_rdy    <= 1'b0;
      stat_lf_rdy    <= 1'b0;
      stat_hf_stable <= 1'b0;
    end else if (clk_en) begin
      ctrl_freq      <= next_ctrl_freq;
      ctrl_scs       <= next_ctrl_scs;
      irq_status     <= next_irq_status;
      irq_mask       <= next_irq_mask;
      irq_snap       <= next_irq_snap;
      prdata         <= next_prdata;
      state          <= next_state;
      act_src        <= next_act_src;
      act_exp        <= next_act_exp;
      tgt_src        <= next_tgt_src;
      tgt_exp        <= next_tgt_exp;
      wait_cnt       <= next_wait_cnt;
      edge_cnt       <= next_edge_cnt;
      cur_prev       <= cur_lvl;
      new_prev       <= new_lvl;
      sys_clk        <= next_sys_clk;
      hf_osc_enable  <= next_hf_en;
      lf_osc_enable  <= next_lf_en;
      stat_hf_rdy    <= next_stat_hf_rdy;
      stat_lf_rdy    <= next_stat_lf_rdy;
      stat_hf_stable <= next_stat_hf_stable;
    end
  end

endmodule : scs_clock_switch

/* core/scs_pkg.sv */
// constants, field layouts and state codes of the system clock switch
// assumes a single 100 MHz pclk domain; oscillator levels arrive on pins
//
// Contract
// - start-up delay when target oscillator is off
// - wait for falling edge of old clock
// - hold low until new clock rises
// - status updated before switch is finished; code latches it in UPDATE, as busy drops
// - same source change skips start-up delay
// - select 00 follows configuration oscillator bits
// - select 01 is reserved, keeps clock
// - select 1x uses internal block frequency
// - reset clears the clock source select
// - switch delay depends on target source
// - frequency field bits 6-3, reset 0111
// - duplicate, 31.25 kHz and LF codes
// - status bit 4 shows HF ready
// - status bit 1 shows LF ready
// - status bit 0 shows HF stable, driving
// - stable only within final frequency tolerance
package scs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned HF_SWITCH_NS     = 2000;
  localparam logic [7:0]  HF_SWITCH_CYC    = 8'((HF_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  EXT_SWITCH_EDGES = 2'h2;
  localparam logic [1:0]  LF_SWITCH_EDGES  = 2'h1;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0c;

  // control fields
  localparam int unsigned FREQ_LSB   = 3;
  localparam int unsigned FREQ_MSB   = 6;
  localparam int unsigned SCS_LSB    = 0;
  localparam int unsigned SCS_MSB    = 1;
  localparam logic [3:0]  FREQ_RESET = 4'h7;
  localparam logic [1:0]  SCS_RESET  = 2'h0;
  localparam logic [1:0]  SCS_CONFIG = 2'h0;
  localparam logic [1:0]  SCS_RESVD  = 2'h1;
  localparam logic [1:0]  CFG_INTERNAL_OSC_BLOCK = 2'h0;

  // status fields
  localparam int unsigned STAT_HF_RDY_BIT    = 4;
  localparam int unsigned STAT_LF_RDY_BIT    = 1;
  localparam int unsigned STAT_HF_STABLE_BIT = 0;

  // interrupt fields
  localparam int unsigned IRQ_W               = 3;
  localparam int unsigned IRQ_SWITCH_DONE_BIT = 0;
  localparam int unsigned IRQ_HF_STABLE_BIT   = 1;
  localparam int unsigned IRQ_RESVD_SEL_BIT   = 2;
  localparam logic [2:0]  IRQ_RESET           = 3'h0;

  // ---------------------------------------------------------------
  // synchronised pin lanes and postscaler
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W      = 8;
  localparam int unsigned IDX_HF      = 0;
  localparam int unsigned IDX_LF      = 1;
  localparam int unsigned IDX_EXT     = 2;
  localparam int unsigned IDX_HF_RDY  = 3;
  localparam int unsigned IDX_HF_SET  = 4;
  localparam int unsigned IDX_LF_RDY  = 5;
  localparam int unsigned IDX_CFG_LSB = 6;
  localparam int unsigned POST_W      = 9;
  localparam logic [3:0]  RESET_EXP   = 4'h5;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_SRC_HF  = 2'h0,
    SCS_SRC_LF  = 2'h1,
    SCS_SRC_EXT = 2'h2
  } scs_src_t;

  typedef enum logic [4:0] {
    SCS_ST_IDLE      = 5'b00001,
    SCS_ST_STARTUP   = 5'b00010,
    SCS_ST_WAIT_FALL = 5'b00100,
    SCS_ST_HOLD_LOW  = 5'b01000,
    SCS_ST_UPDATE    = 5'b10000
  } scs_state_t;

endpackage : scs_pkg

/* core/scs_osc_if.sv */
// bundle of synchronised oscillator levels and postscaler count
// assumes all members live in the pclk domain
`timescale 1ns/10ps
interface scs_osc_if;
  logic [scs_pkg::SYNC_W-1:0] lvl;
  logic [scs_pkg::POST_W-1:0] div_cnt;

  modport sync_mp (output lvl);
  modport post_mp (input lvl, output div_cnt);
  modport core_mp (input lvl, input div_cnt);
endinterface : scs_osc_if

/* core/scs_sync3.sv */
// three-stage pin synchroniser with agreement filter
// assumes raw inputs are asynchronous to pclk
`timescale 1ns/10ps
module scs_sync3 #(
  parameter int unsigned N = scs_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // pins
  input  wire logic [N-1:0] raw,
  // synchronised levels
  scs_osc_if.sync_mp        osc
);
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  logic [N-1:0] q;
  logic [N-1:0] next_q;

  // a lane changes only once stages two and three agree
  always_comb begin
    next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
  end

  // s1 is seen by s2 only, never by the filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else if (clk_en) begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

  assign osc.lvl = q;
endmodule : scs_sync3

/* core/scs_postscaler.sv */
// postscaler counting rising edges of the synchronised HF level
// assumes HF is well below half the pclk rate
`timescale 1ns/10ps
module scs_postscaler (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  clk_en,
  // oscillator bundle
  scs_osc_if.post_mp osc
);
  logic                       hf_prev;
  logic [scs_pkg::POST_W-1:0] cnt;
  logic [scs_pkg::POST_W-1:0] next_cnt;

  // bit k of the count is HF divided by 2^(k+1)
  always_comb begin
    next_cnt = cnt;
    if (osc.lvl[scs_pkg::IDX_HF] && !hf_prev) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_prev <= 1'b0;
      cnt     <= '0;
    end else if (clk_en) begin
      hf_prev <= osc.lvl[scs_pkg::IDX_HF];
      cnt     <= next_cnt;
    end
  end

  assign osc.div_cnt = cnt;
endmodule : scs_postscaler

/* dv/scs_clock_switch_checker.sv */
// port checks for the system clock switch
// assumes bind onto scs_clock_switch, one pclk domain
`timescale 1ns/10ps
module scs_clock_switch_checker (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // switch outputs
  input wire logic        sys_clk,
  input wire logic        switch_busy,
  input wire logic        irq
);
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write strobe in the access phase
  wire acc = psel && penable && pwrite;

  rst_idle_a: assert property ($rose(presetn) |-> !switch_busy && !sys_clk && !irq)
    else $error("outputs not idle after reset");
  resvd_hold_a: assert property (acc && paddr == 8'h00 && pwdata[1:0] == 2'h1 && !switch_busy |-> ##2 !switch_busy)
    else $error("reserved select started a switch");
  high_phase_a: assert property ($rose(sys_clk) |=> sys_clk [*2])
    else $error("short high phase on sys_clk");
  low_phase_a: assert property ($fell(sys_clk) |=> !sys_clk [*2])
    else $error("short low phase on sys_clk");
  busy_min_a: assert property ($rose(switch_busy) |-> switch_busy [*3])
    else $error("switch skipped its stages");
  mask_off_a: assert property (acc && paddr == 8'h0c && pwdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("irq high with all events masked");
  ctrl_ok_a: assert property (psel && penable && paddr == 8'h00 |-> !pslverr)
    else $error("error on control access");
  stat_ok_a: assert property (psel && penable && paddr == 8'h04 |-> !pslverr)
    else $error("error on status access");
  unmapped_a: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
    else $error("no error on unmapped access");

  // main scenarios reached
  cover property ($rose(switch_busy));
  cover property ($rose(irq));
  cover property (acc && paddr == 8'h00 && pwdata[1:0] == 2'h1);
endmodule : scs_clock_switch_checker

bind scs_clock_switch scs_clock_switch_checker chk_i (.*);

/* dv/system_clock_switch_control_bench.sv */
// self-checking bench for the system clock switch
// assumes scs_clock_switch top; bench drives apb and oscillator pins
`timescale 1ns/10ps
module system_clock_switch_control_bench;
  logic        pclk, presetn, psel, penable, pwrite, hf, lf, ext;
  logic        pready, pslverr, sys_clk, busy, irq, hf_en, lf_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [33:0] exp_q[$];
  logic [3:0]  codes[5] = '{4'hf, 4'hb, 4'h4, 4'h2, 4'h0};
  int          miscompares, check_count, n;

  // ready pins and configuration held, so the switch logic is what moves
  scs_clock_switch dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_osc_in(hf), .lf_osc_in(lf), .ext_clk_in(ext), .hf_osc_running(1'b1), .hf_osc_settled(1'b1),
    .lf_osc_running(1'b1), .cfg_osc_select(2'h0), .sys_clk(sys_clk), .hf_osc_enable(hf_en),
    .lf_osc_enable(lf_en), .switch_busy(busy), .irq(irq));

  // ----------------
  // clock and pins
  // ----------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // oscillators kept slow: every phase spans several pclk cycles
  always @(posedge pclk) begin
    n <= n + 1;
    hf <= (n % 10) < 5;
    lf <= (n % 50) < 25;
    ext <= (n % 14) < 7;
  end

  // ----------------
  // checking
  // ----------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : chk

  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // each completed read takes the oldest note as {irq, pslverr, prdata}
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk({irq, pslverr, prdata}, exp_q.pop_front());

  // one apb transfer; a read notes its expectation first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    if (!wr) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // a switch must start within 20 cycles and end within 12000, over two periods of the slowest old clock
  task automatic wait_sw;
    int k;
    for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge pclk);
    chk({33'h0, busy}, 34'h1);
    for (k = 0; k < 12000 && busy !== 1'b0; k++) @(posedge pclk);
    chk({33'h0, busy}, 34'h0);
  endtask : wait_sw

  // watchdog far beyond the slowest sequence
  initial begin
    #600000;
    miscompares++;
    wrap_up;
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(32'hd75097b0));
    {psel, penable, pwrite, paddr, pwdata, n, hf, lf, ext} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(1'b0, 8'h00, 0, 34'h38);
    apb(1'b0, 8'h04, 0, 34'h13);
    apb(1'b0, 8'h08, 0, 34'h2);
    chk({32'h0, hf_en, lf_en}, 34'h2);
    apb(1'b1, 8'h0c, 5, 0);
    // random filler in the unused control bits must read back as zero; last code moves to LF
    foreach (codes[i]) begin
      r = $urandom;
      r[6:3] = codes[i];
      r[1:0] = 2'h2;
      apb(1'b1, 8'h00, r, 0);
      wait_sw();
      apb(1'b0, 8'h08, 0, 34'h2_0000_0001);
      apb(1'b0, 8'h00, 0, {27'h0, codes[i], 3'h2});
    end
    // LF now drives: HF request dropped, LF request held
    chk({32'h0, hf_en, lf_en}, 34'h1);
    apb(1'b1, 8'h00, 32'h49, 0);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h08, 0, 34'h2_0000_0004);
    apb(1'b0, 8'h00, 0, 34'h49);
    apb(1'b1, 8'h04, 32'hffffffff, 0);
    apb(1'b0, 8'h04, 0, 34'h12);
    apb(1'b0, 8'h40, 0, 34'h1_0000_0000);
    apb(1'b1, 8'h0c, 0, 0);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 0, 34'h38);
    // let the read checker see the last access before the verdict
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule : system_clock_switch_control_bench
